// [logic/reset_seq_pkg.sv]
/*
 * constants shared by the reset and start-up sequencer: timing, register
 * indices, reset values, field positions, oscillator codes and states.
 * assumes a 200 MHz system clock.
 */
package reset_seq_pkg;

   // timing
   localparam int CLK_PERIOD_NS  = 5;
   localparam int POWER_UP_DELAY_TIMER_TIME_MS   = 72;
   localparam int RC_TICK_NS     = 1000;
   localparam int RC_DIV_CYCLES  = RC_TICK_NS / CLK_PERIOD_NS;
   localparam int POWER_UP_DELAY_TIMER_TICKS     = POWER_UP_DELAY_TIMER_TIME_MS * 1000000 / RC_TICK_NS;
   localparam int OST_CYCLES     = 1024;
   localparam int FILTER_CYCLES  = 4;

   // register indices, byte address is four times the index
   localparam logic [7:0] IDX_STATUS       = 8'h03;
   localparam logic [7:0] IDX_INTCTL       = 8'h0b;
   localparam logic [7:0] IDX_PFLAG        = 8'h0c;
   localparam logic [7:0] IDX_SCRATCH      = 8'h20;
   localparam logic [7:0] IDX_SEQ          = 8'h40;
   localparam logic [7:0] IDX_OPTION       = 8'h81;
   localparam logic [7:0] IDX_POWER_STATUS = 8'h8e;
   localparam logic [7:0] IDX_OSC_TRIM     = 8'h8f;

   // reset values
   localparam logic [7:0]  STATUS_POR       = 8'h18;
   localparam logic [7:0]  OPTION_RST       = 8'hff;
   localparam logic [7:0]  INTCTL_RST       = 8'h00;
   localparam logic [7:0]  PFLAG_RST        = 8'h00;
   localparam logic [7:0]  OSC_TRIM_POR     = 8'h80;
   localparam logic [7:0]  POWER_STATUS_POR = 8'h00;
   localparam logic [7:0]  SCRATCH_RST      = 8'h00;
   localparam logic [12:0] PC_RESET         = 13'h0000;
   localparam logic [12:0] PC_VECTOR        = 13'h0004;

   // field positions and masks
   localparam int         STATUS_TIMEOUT_BIT   = 4;
   localparam int         STATUS_POWERDOWN_BIT = 3;
   localparam int         POWER_ON_BIT         = 1;
   localparam int         INT_ENABLE_BIT       = 7;
   localparam int         INTCTL_KEEP_BIT      = 0;
   localparam logic [7:0] STATUS_UPPER_MASK    = 8'he0;
   localparam logic [7:0] STATUS_SW_MASK       = 8'he7;
   localparam logic [7:0] POWER_STATUS_MASK    = 8'h02;
   localparam logic [7:0] OSC_TRIM_MASK        = 8'hfc;

   // oscillator select codes
   localparam logic [2:0] OSC_LOW_POWER_CRYSTAL = 3'b000;
   localparam logic [2:0] OSC_STANDARD_CRYSTAL  = 3'b001;
   localparam logic [2:0] OSC_HIGH_SPEED_CRYSTAL = 3'b010;
   localparam logic [2:0] OSC_INTERNAL_RC_CLKOUT = 3'b101;
   localparam logic [2:0] OSC_EXTERNAL_RC_CLKOUT = 3'b111;

   typedef enum logic [4:0] {
      S_POR  = 5'b00001,
      S_POWER_UP_DELAY_TIMER = 5'b00010,
      S_OST  = 5'b00100,
      S_PIN  = 5'b01000,
      S_RUN  = 5'b10000
   } seq_state_e;

endpackage : reset_seq_pkg

// [logic/reset_pin_filter.sv]
/*
 * synchroniser and glitch filter for the active-low external reset pin.
 * assumes the pin is asynchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none

module reset_pin_filter #(
   parameter int CYCLES = reset_seq_pkg::FILTER_CYCLES
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // pin and result
   input  wire logic pin_n,
   output logic      filtered_n
);

   localparam int         CW   = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

   typedef struct packed {
      logic          meta;
      logic          sync;
      logic          level;
      logic [CW-1:0] cnt;
   } filt_s;

   filt_s q;
   filt_s d;

   always_comb begin
      d      = q;
      d.meta = pin_n;
      d.sync = q.meta;
      // a new level must hold for CYCLES samples before it is taken
      if (q.sync == q.level) begin
         d.cnt = '0;
      end else if (q.cnt == LAST) begin
         d.level = q.sync;
         d.cnt   = '0;
      end else begin
         d.cnt = q.cnt + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign filtered_n = q.level;

endmodule : reset_pin_filter
`default_nettype wire

// [logic/power_up_delay_timer.sv]
/*
 * power-up delay timer: a slow rc-rate tick from a divider of clk drives
 * a tick counter; done rises after TICKS ticks and holds until restart.
 * assumes start is a one-cycle pulse on clk.
 */
`timescale 1ns/1ps
`default_nettype none

module power_up_delay_timer #(
   parameter int DIV   = reset_seq_pkg::RC_DIV_CYCLES,
   parameter int TICKS = reset_seq_pkg::POWER_UP_DELAY_TIMER_TICKS
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // control
   input  wire logic start,
   output logic      done
);

   localparam int            DW       = $clog2(DIV + 1);
   localparam int            TW       = $clog2(TICKS + 1);
   localparam logic [DW-1:0] DIV_LAST = DW'(DIV - 1);
   localparam logic [TW-1:0] TCK_LAST = TW'(TICKS - 1);

   typedef struct packed {
      logic [DW-1:0] div;
      logic [TW-1:0] ticks;
      logic          running;
      logic          done;
   } tmr_s;

   tmr_s q;
   tmr_s d;

   always_comb begin
      d = q;
      if (start) begin
         d = '0;
         d.running = 1'b1;
      end else if (q.running) begin
         if (q.div == DIV_LAST) begin
            d.div = '0;
            // one rc tick
            if (q.ticks == TCK_LAST) begin
               d.running = 1'b0;
               d.done    = 1'b1;
            end else begin
               d.ticks = q.ticks + 1'b1;
            end
         end else begin
            d.div = q.div + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign done = q.done;

endmodule : power_up_delay_timer
`default_nettype wire

// [logic/reset_and_startup_sequencer.sv]
/*
 * reset and start-up sequencer: tells reset causes apart, runs the
 * power-up delay and oscillator start-up count, keeps cause flags and
 * per-cause reset values of the special registers, Avalon-MM slave.
 * assumes watchdog and wake inputs come from logic on clk; the supply
 * detector, reset pin and oscillator input are asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none

// Function
// - separate power-on, pin reset running, pin reset in sleep, watchdog reset
// - resets load reset values; watchdog wake-up leaves registers untouched
// - some registers are never initialised by any reset
// - reset pin passes a noise filter before it acts
// - watchdog reset acts internally, never drives the reset pin
// - supply rise makes an internal power-on reset pulse
// - after power-on the power-up delay holds reset nominal 72 ms
// - active-low enable bit selects power-up delay, high skips it
// - after power-up delay count 1024 oscillator input cycles
// - start-up count only in crystal modes, on power-on or wake-up
// - power-up delay after power-on pulse, then start-up count
// - rc mode with delay disabled gives no start-up delay
// - delays run from power-on pulse; low pin just holds execution
// - power-on clears power-on flag bit 1, else unchanged
// - timeout and power-down flags record the reset cause
// - program counter 000h on reset; wake resumes or vectors 0004h
// - status 0001 1xxx on power-on, upper forced otherwise
// - option, interrupt control and trim reset values per cause
// - interrupt wake-up sets the waking flag bits only
// - every reset clears the global interrupt enable
// - rc-with-clock-out codes are 101 and 111
module reset_and_startup_sequencer #(
   parameter int FILTER_CYCLES = reset_seq_pkg::FILTER_CYCLES,
   parameter int RC_DIV_CYCLES = reset_seq_pkg::RC_DIV_CYCLES,
   parameter int POWER_UP_DELAY_TIMER_TICKS    = reset_seq_pkg::POWER_UP_DELAY_TIMER_TICKS,
   parameter int OST_CYCLES    = reset_seq_pkg::OST_CYCLES
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // pins and detector
   input  wire logic        supply_rise_por,
   input  wire logic        external_reset_pin_n,
   input  wire logic        oscillator_input_pin,
   // configuration
   input  wire logic [2:0]  osc_select_field,
   input  wire logic        power_up_delay_enable_n,
   // core events
   input  wire logic        watchdog_timeout,
   input  wire logic        in_sleep,
   input  wire logic        interrupt_wake,
   input  wire logic [2:0]  wake_intctl_flags,
   input  wire logic [7:0]  wake_periph_flags,
   input  wire logic [12:0] pc_current,
   // core control
   output logic             chip_reset_n,
   output logic             core_run,
   output logic             pc_load,
   output logic [12:0]      pc_load_value,
   // avalon-mm slave
   input  wire logic [9:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [3:0]  avs_byteenable,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest
);

   localparam int            OW       = $clog2(OST_CYCLES + 1);
   localparam logic [OW-1:0] OST_LAST = OW'(OST_CYCLES - 1);

   typedef struct packed {
      reset_seq_pkg::seq_state_e state;
      logic          por_meta;
      logic          por_sync;
      logic          osc_meta;
      logic          osc_sync;
      logic          osc_prev;
      logic [OW-1:0] ost_cnt;
      logic          wake_pending;
      logic [12:0]   wake_pc;
      logic          chip_reset_n;
      logic          core_run;
      logic          pc_load;
      logic [12:0]   pc_value;
      logic [7:0]    status;
      logic [7:0]    option;
      logic [7:0]    intctl;
      logic [7:0]    pflag;
      logic [7:0]    osc_trim;
      logic [7:0]    power_status;
      logic [7:0]    scratch;
      logic          waitrequest;
      logic [31:0]   readdata;
   } seq_s;

   seq_s q;
   seq_s d;

   logic pin_ok_n;
   logic power_up_delay_timer_done;
   logic power_up_delay_timer_start;

   ////////////////////////////////////////////////////////////////////////
   // pin filter and power-up delay timer

   reset_pin_filter #(
      .CYCLES     (FILTER_CYCLES)
   ) u_filter (
      .clk        (clk),
      .rst_n      (rst_n),
      .pin_n      (external_reset_pin_n),
      .filtered_n (pin_ok_n)
   );

   power_up_delay_timer #(
      .DIV   (RC_DIV_CYCLES),
      .TICKS (POWER_UP_DELAY_TIMER_TICKS)
   ) u_power_up_delay_timer (
      .clk   (clk),
      .rst_n (rst_n),
      .start (power_up_delay_timer_start),
      .done  (power_up_delay_timer_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic is_crystal(input logic [2:0] sel);
      is_crystal = (sel == reset_seq_pkg::OSC_LOW_POWER_CRYSTAL) ||
                   (sel == reset_seq_pkg::OSC_STANDARD_CRYSTAL) ||
                   (sel == reset_seq_pkg::OSC_HIGH_SPEED_CRYSTAL);
   endfunction : is_crystal

   function automatic logic [7:0] reg_read(input seq_s s,
                                           input logic [7:0] idx);
      case (idx)
         reset_seq_pkg::IDX_STATUS:       reg_read = s.status;
         reset_seq_pkg::IDX_INTCTL:       reg_read = s.intctl;
         reset_seq_pkg::IDX_PFLAG:        reg_read = s.pflag;
         reset_seq_pkg::IDX_SCRATCH:      reg_read = s.scratch;
         reset_seq_pkg::IDX_SEQ:          reg_read = {3'h0, s.state};
         reset_seq_pkg::IDX_OPTION:       reg_read = s.option;
         reset_seq_pkg::IDX_POWER_STATUS: reg_read = s.power_status;
         reset_seq_pkg::IDX_OSC_TRIM:     reg_read = s.osc_trim;
         default:                         reg_read = 8'h00;
      endcase
   endfunction : reg_read

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      logic       crystal;
      logic       osc_rise;
      logic       sleeping;
      logic [7:0] idx;
      logic [7:0] wd;
      logic       rst_evt;
      crystal  = 1'b0;
      osc_rise = 1'b0;
      sleeping = 1'b0;
      idx      = 8'h00;
      wd       = 8'h00;
      rst_evt  = 1'b0;

      d          = q;
      d.pc_load  = 1'b0;
      power_up_delay_timer_start = 1'b0;
      d.por_meta = supply_rise_por;
      d.por_sync = q.por_meta;
      d.osc_meta = oscillator_input_pin;
      d.osc_sync = q.osc_meta;
      d.osc_prev = q.osc_sync;
      crystal  = is_crystal(osc_select_field);
      osc_rise = q.osc_sync & ~q.osc_prev;
      sleeping = in_sleep | q.wake_pending;
      idx      = avs_address[9:2];
      wd       = avs_writedata[7:0];

      // bus: answer one cycle after the request, write at the edge that ends the answer cycle
      if ((avs_read || avs_write) && q.waitrequest) begin
         d.waitrequest = 1'b0;
         if (avs_read) begin
            d.readdata = {24'h0, reg_read(q, idx)};
         end
      end else begin
         d.waitrequest = 1'b1;
         if (avs_write && !q.waitrequest && avs_byteenable[0]) begin
            case (idx)
               reset_seq_pkg::IDX_STATUS:
                  d.status = (q.status & ~reset_seq_pkg::STATUS_SW_MASK) |
                             (wd & reset_seq_pkg::STATUS_SW_MASK);
               reset_seq_pkg::IDX_INTCTL:       d.intctl  = wd;
               reset_seq_pkg::IDX_PFLAG:        d.pflag   = wd;
               reset_seq_pkg::IDX_SCRATCH:      d.scratch = wd;
               reset_seq_pkg::IDX_OPTION:       d.option  = wd;
               reset_seq_pkg::IDX_POWER_STATUS:
                  d.power_status = wd & reset_seq_pkg::POWER_STATUS_MASK;
               reset_seq_pkg::IDX_OSC_TRIM:
                  d.osc_trim = wd & reset_seq_pkg::OSC_TRIM_MASK;
               default: ;
            endcase
         end
      end

      // start-up sequence
      case (q.state)
         reset_seq_pkg::S_POR: begin
            if (!q.por_sync) begin
               if (!power_up_delay_enable_n) begin
                  d.state    = reset_seq_pkg::S_POWER_UP_DELAY_TIMER;
                  power_up_delay_timer_start = 1'b1;
               end else if (crystal) begin
                  d.state   = reset_seq_pkg::S_OST;
                  d.ost_cnt = '0;
               end else begin
                  d.state = reset_seq_pkg::S_PIN;
               end
            end
         end
         reset_seq_pkg::S_POWER_UP_DELAY_TIMER: begin
            if (power_up_delay_timer_done) begin
               d.ost_cnt = '0;
               d.state   = crystal ? reset_seq_pkg::S_OST
                                   : reset_seq_pkg::S_PIN;
            end
         end
         reset_seq_pkg::S_OST: begin
            if (osc_rise) begin
               if (q.ost_cnt == OST_LAST) begin
                  if (q.wake_pending) begin
                     d.state        = reset_seq_pkg::S_RUN;
                     d.core_run     = 1'b1;
                     d.pc_load      = 1'b1;
                     d.pc_value     = q.wake_pc;
                     d.wake_pending = 1'b0;
                  end else begin
                     d.state = reset_seq_pkg::S_PIN;
                  end
               end else begin
                  d.ost_cnt = q.ost_cnt + 1'b1;
               end
            end
         end
         reset_seq_pkg::S_PIN: begin
            // delays already over, execution waits only for the pin
            if (pin_ok_n) begin
               d.state        = reset_seq_pkg::S_RUN;
               d.chip_reset_n = 1'b1;
               d.core_run     = 1'b1;
            end
         end
         reset_seq_pkg::S_RUN: ;
         default: d.state = reset_seq_pkg::S_POR;
      endcase

      // reset causes, power-on first; events win over bus writes
      if (q.por_sync) begin
         d.state        = reset_seq_pkg::S_POR;
         d.wake_pending = 1'b0;
         d.chip_reset_n = 1'b0;
         d.core_run     = 1'b0;
         d.pc_load      = 1'b1;
         d.pc_value     = reset_seq_pkg::PC_RESET;
         d.status       = reset_seq_pkg::STATUS_POR;
         d.option       = reset_seq_pkg::OPTION_RST;
         d.intctl       = reset_seq_pkg::INTCTL_RST;
         d.pflag        = reset_seq_pkg::PFLAG_RST;
         d.osc_trim     = reset_seq_pkg::OSC_TRIM_POR;
         d.power_status = reset_seq_pkg::POWER_STATUS_POR;
      end else if (q.chip_reset_n && !pin_ok_n) begin
         rst_evt = 1'b1;
         if (sleeping) begin
            d.status[reset_seq_pkg::STATUS_TIMEOUT_BIT]   = 1'b1;
            d.status[reset_seq_pkg::STATUS_POWERDOWN_BIT] = 1'b0;
         end
      end else if (q.chip_reset_n && watchdog_timeout) begin
         if (sleeping) begin
            // wake-up: registers untouched, resume at next address
            d.status[reset_seq_pkg::STATUS_TIMEOUT_BIT]   = 1'b0;
            d.status[reset_seq_pkg::STATUS_POWERDOWN_BIT] = 1'b0;
            d.wake_pc = pc_current + 13'h0001;
            d.state   = reset_seq_pkg::S_OST;
         end else begin
            // internal only, the pin stays an input
            rst_evt = 1'b1;
            d.status[reset_seq_pkg::STATUS_TIMEOUT_BIT]   = 1'b0;
            d.status[reset_seq_pkg::STATUS_POWERDOWN_BIT] = 1'b1;
         end
      end else if (q.chip_reset_n && interrupt_wake && in_sleep &&
                   q.state == reset_seq_pkg::S_RUN) begin
         d.status[reset_seq_pkg::STATUS_TIMEOUT_BIT]   = 1'b1;
         d.status[reset_seq_pkg::STATUS_POWERDOWN_BIT] = 1'b0;
         d.intctl[2:0] = d.intctl[2:0] | wake_intctl_flags;
         d.pflag       = d.pflag | wake_periph_flags;
         d.wake_pc = q.intctl[reset_seq_pkg::INT_ENABLE_BIT]
                   ? reset_seq_pkg::PC_VECTOR
                   : pc_current + 13'h0001;
         d.state   = reset_seq_pkg::S_OST;
      end

      // wake-up: start-up count only for a crystal
      if (d.state == reset_seq_pkg::S_OST && q.state == reset_seq_pkg::S_RUN
          && !rst_evt) begin
         d.ost_cnt = '0;
         if (crystal) begin
            d.wake_pending = 1'b1;
            d.core_run     = 1'b0;
         end else begin
            d.state    = reset_seq_pkg::S_RUN;
            d.pc_load  = 1'b1;
            d.pc_value = d.wake_pc;
         end
      end

      // pin and watchdog resets share the register reset values
      if (rst_evt) begin
         d.state        = reset_seq_pkg::S_PIN;
         d.wake_pending = 1'b0;
         d.chip_reset_n = 1'b0;
         d.core_run     = 1'b0;
         d.pc_load      = 1'b1;
         d.pc_value     = reset_seq_pkg::PC_RESET;
         d.status       = d.status & ~reset_seq_pkg::STATUS_UPPER_MASK;
         d.option       = reset_seq_pkg::OPTION_RST;
         d.intctl       = {7'h00, q.intctl[reset_seq_pkg::INTCTL_KEEP_BIT]};
         d.pflag        = reset_seq_pkg::PFLAG_RST;
      end
      // scratch is never touched by any cause
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q              <= '0;
         q.state        <= reset_seq_pkg::S_POR;
         q.status       <= reset_seq_pkg::STATUS_POR;
         q.option       <= reset_seq_pkg::OPTION_RST;
         q.intctl       <= reset_seq_pkg::INTCTL_RST;
         q.pflag        <= reset_seq_pkg::PFLAG_RST;
         q.osc_trim     <= reset_seq_pkg::OSC_TRIM_POR;
         q.power_status <= reset_seq_pkg::POWER_STATUS_POR;
         q.scratch      <= reset_seq_pkg::SCRATCH_RST;
         q.pc_value     <= reset_seq_pkg::PC_RESET;
         q.waitrequest  <= 1'b1;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign chip_reset_n    = q.chip_reset_n;
   assign core_run        = q.core_run;
   assign pc_load         = q.pc_load;
   assign pc_load_value   = q.pc_value;
   assign avs_readdata    = q.readdata;
   assign avs_waitrequest = q.waitrequest;

endmodule : reset_and_startup_sequencer
`default_nettype wire

// [test/osc_pin_model.sv]
/* far side model: oscillator source and reset pin driver.
   assumes the bench asks for reset through hold_n. */
`timescale 1ns/1ps
`default_nettype none
module osc_pin_model (
   // request from the bench
   input  wire logic hold_n,
   // pins
   output var logic  oscillator_input_pin,
   output wire logic external_reset_pin_n
);
   // free-running, unrelated in phase to clk
   initial begin
      oscillator_input_pin = 1'b0;
      forever #7 oscillator_input_pin = ~oscillator_input_pin;
   end
   assign external_reset_pin_n = hold_n;
endmodule : osc_pin_model
`default_nettype wire

// [test/seq_props.sv]
/* checker of sequencer and bus behaviour at the top ports.
   assumes it is bound into the sequencer top by name. */
`timescale 1ns/1ps
`default_nettype none
module seq_props (
   // watched ports
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        supply_rise_por,
   input wire logic        external_reset_pin_n,
   input wire logic [2:0]  osc_select_field,
   input wire logic        power_up_delay_enable_n,
   input wire logic        watchdog_timeout,
   input wire logic        in_sleep,
   input wire logic        chip_reset_n,
   input wire logic        core_run,
   input wire logic        pc_load,
   input wire logic [12:0] pc_load_value,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_wd;
      watchdog_timeout && chip_reset_n && !in_sleep
         |=> !chip_reset_n && pc_load && pc_load_value == 13'h0000;
   endproperty
   a_wd: assert property (p_wd) else $error("watchdog reset missed");
   property p_hold;
      !chip_reset_n |-> !core_run;
   endproperty
   a_hold: assert property (p_hold) else $error("core runs in reset");
   property p_ans;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_ans: assert property (p_ans) else $error("bus answer late");
   property p_one;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_one: assert property (p_one) else $error("answer too long");
   property p_rdz;
      !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000;
   endproperty
   a_rdz: assert property (p_rdz) else $error("upper data set");
   property p_por;
      supply_rise_por [*4] |-> !chip_reset_n;
   endproperty
   a_por: assert property (p_por) else $error("no power-on reset");
   property p_pin;
      $rose(chip_reset_n) |-> $past(external_reset_pin_n, 2);
   endproperty
   a_pin: assert property (p_pin) else $error("release with pin low");
   property p_rc;
      $fell(supply_rise_por) && osc_select_field[2] && power_up_delay_enable_n
         && external_reset_pin_n |-> ##[1:12] chip_reset_n;
   endproperty
   a_rc: assert property (p_rc) else $error("rc start delayed");
endmodule : seq_props
bind reset_and_startup_sequencer seq_props u_props (.*);
`default_nettype wire

// [test/tb_top.sv]
/* self-checking bench of the reset and start-up sequencer.
   assumes shortened counts: power_up_delay_timer 10 ticks of 2 cycles, ost 8. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 0, rst_n = 0, supply_rise_por = 0, watchdog_timeout = 0;
   logic in_sleep = 0, interrupt_wake = 0, hold_n = 1;
   logic power_up_delay_enable_n = 0, avs_read = 0, avs_write = 0;
   logic [2:0]  osc_select_field = 3'b001, wake_intctl_flags = 3'h0;
   logic [7:0]  wake_periph_flags = 8'h00;
   logic [12:0] pc_current = 13'h0000;
   logic [9:0]  avs_address = 10'h000;
   logic [3:0]  avs_byteenable = 4'hf;
   logic [31:0] avs_writedata = 32'h0;
   wire logic   external_reset_pin_n, oscillator_input_pin, chip_reset_n;
   wire logic   core_run, pc_load, avs_waitrequest;
   wire logic [12:0] pc_load_value;
   wire logic [31:0] avs_readdata;
   int miscompares = 0, n_compared = 0, n;
   always #2.5 clk = ~clk;
   osc_pin_model prt (.hold_n(hold_n),
      .oscillator_input_pin(oscillator_input_pin),
      .external_reset_pin_n(external_reset_pin_n));
   reset_and_startup_sequencer #(.FILTER_CYCLES(2), .RC_DIV_CYCLES(2),
      .POWER_UP_DELAY_TIMER_TICKS(10), .OST_CYCLES(8)) uut (.*);
   task automatic close_out();
      $display("compared %0d, miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   task automatic chk(input logic [12:0] g, input logic [12:0] e);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] e);
      avs_address <= {a, 2'b00};
      avs_writedata <= {24'h0, e};
      avs_read <= !w;
      avs_write <= w;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      if (!w) chk({5'h0, avs_readdata[7:0]}, {5'h0, e});
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask : bus
   task automatic wrel();
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (chip_reset_n !== 1'b1 && n < 300);
      chk({12'h0, chip_reset_n}, 13'h0001);
      @(posedge clk);
   endtask : wrel
   task automatic wpc(input logic [12:0] e);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (pc_load !== 1'b1 && n < 300);
      chk({12'h0, pc_load}, 13'h0001);
      chk(pc_load_value, e);
      @(posedge clk);
   endtask : wpc
   task automatic por();
      supply_rise_por <= 1'b1;
      repeat (4) @(posedge clk);
      supply_rise_por <= 1'b0;
      wrel();
   endtask : por
   task automatic wd();
      watchdog_timeout <= 1'b1;
      @(posedge clk);
      watchdog_timeout <= 1'b0;
   endtask : wd
   initial begin
      #100us;
      miscompares++;
      close_out();
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      por();
      chk({12'h0, n > 20}, 13'h0001);
      bus(8'h03, 0, 8'h18);
      bus(8'h81, 0, 8'hff);
      bus(8'h8f, 0, 8'h80);
      bus(8'h8e, 0, 8'h00);
      bus(8'h0b, 0, 8'h00);
      bus(8'h8e, 1, 8'h02);
      bus(8'h81, 1, 8'h12);
      bus(8'h20, 1, 8'h5a);
      bus(8'h0b, 1, 8'h80);
      wd();
      wrel();
      bus(8'h03, 0, 8'h08);
      bus(8'h81, 0, 8'hff);
      bus(8'h8e, 0, 8'h02);
      bus(8'h20, 0, 8'h5a);
      bus(8'h0b, 0, 8'h00);
      bus(8'h10, 0, 8'h00);
      hold_n <= 1'b0;
      @(posedge clk);
      hold_n <= 1'b1;
      repeat (10) @(negedge clk);
      chk({12'h0, chip_reset_n}, 13'h0001);
      @(posedge clk);
      hold_n <= 1'b0;
      repeat (10) @(negedge clk);
      chk({12'h0, chip_reset_n}, 13'h0000);
      @(posedge clk);
      hold_n <= 1'b1;
      wrel();
      bus(8'h03, 0, 8'h08);
      bus(8'h81, 1, 8'h12);
      bus(8'h0b, 1, 8'h80);
      in_sleep <= 1'b1;
      pc_current <= 13'h0100;
      wake_intctl_flags <= 3'b010;
      @(posedge clk);
      interrupt_wake <= 1'b1;
      @(posedge clk);
      interrupt_wake <= 1'b0;
      wpc(13'h0004);
      in_sleep <= 1'b0;
      bus(8'h0b, 0, 8'h82);
      bus(8'h03, 0, 8'h10);
      bus(8'h81, 0, 8'h12);
      osc_select_field <= 3'b101;
      power_up_delay_enable_n <= 1'b1;
      por();
      chk({12'h0, n < 12}, 13'h0001);
      bus(8'h8e, 0, 8'h00);
      in_sleep <= 1'b1;
      pc_current <= 13'h0123;
      wd();
      wpc(13'h0124);
      in_sleep <= 1'b0;
      bus(8'h03, 0, 8'h00);
      close_out();
   end
endmodule : tb_top
`default_nettype wire
